// ==== hdl/mem_timer.v ====
`timescale 1ns/10ps
// Load N: done is high in the N-th cycle after the load, N >= 1
module mem_timer #(
   parameter W = 6
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire         load,
   input  wire [W-1:0] load_val,
   output wire         done
);
   reg [W-1:0] cnt_reg;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= {W{1'b0}};
      end else if (load) begin
         cnt_reg <= load_val - {{(W-1){1'b0}}, 1'b1};
      end else if (cnt_reg != {W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt_reg == {W{1'b0}});
endmodule

// ==== hdl/static_memory_timing_config.v ====
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "static_mem_map.vh"

// Operation
// - Three registers, each a chip select pair: odd bank high half, even bank low.
// - Every timing field but recovery (bits 14:12, units of two clocks) counts memory clock cycles.
// - Sync-enabled lower four banks ignore their half on reads except the bus width.
// - Sync flash writes run asynchronously with the programmed timing.
// - Bit 15 picks buffered (0) or streamed (1) read return.
// - Buffer mode leaves memory bus alone; a transaction finishes before next.
// - Sync-enabled banks always stream; bit 15 reads back as written.
// - Bits 14:12 times two clocks of recovery before any next chip select.
// - Burst ROM subsequent reads sample data after next-access plus one clocks.
// - SRAM write enable stays low for first-access plus one clocks.
// - VARIABLE_LATENCY_IO strobes high between beats next-access plus one clocks; field at least 2.
// - Bits 2:0 select memory type; codes above four reserved.
// - Bit 3 selects 32-bit (0) or 16-bit (1) data bus.
// - First non-VARIABLE_LATENCY_IO read samples data after first-access plus two clocks.
module static_memory_timing_config #(
   parameter AW = 8
) (
   input  wire          mclk,
   input  wire          rst_b,
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   input  wire [3:0]    sync_static_enable,
   input  wire          boot_width_16,
   input  wire          req_valid,
   output wire          req_ready,
   input  wire [2:0]    req_bank,
   input  wire          req_write,
   input  wire [3:0]    req_beats_m1,
   output reg           req_done,
   output reg           beat_done,
   output reg           sync_read_start,
   output reg           read_stream,
   output reg           bus_width_16,
   input  wire          mem_ready,
   output reg  [5:0]    chip_select_n,
   output reg           output_enable_n,
   output reg           write_enable_n,
   output reg           io_write_strobe_n,
   output wire          sdram_cs_allow
);
   localparam ST_IDLE   = 3'h0;
   localparam ST_RD     = 3'h1;
   localparam ST_RD_GAP = 3'h2;
   localparam ST_WR     = 3'h3;
   localparam ST_WR_GAP = 3'h4;
   localparam ST_RECOV  = 3'h5;

   reg  [1:0]  rst_sync;
   wire        rst_n = rst_sync[1];

   reg  [31:0] cfg_reg [0:2];
   reg  [AW-1:0] awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         aw_hold;
   reg         w_hold;
   reg  [1:0]  in_s1;
   reg  [1:0]  in_s2;
   reg  [1:0]  in_s3;
   reg         rdy_q;
   reg         strap_q;
   reg  [1:0]  strap_cnt;
   reg         strap_done;

   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [15:0] half_reg;
   reg  [3:0]  beats_reg;
   reg  [3:0]  beats_next;
   reg         tload;
   reg  [5:0]  tval;
   wire        tdone;

   function [2:0] decode;
      input [AW-1:0] a;
      begin
         case (a[7:0])
            `CFG_PAIR0_OFS: decode = 3'h4;
            `CFG_PAIR1_OFS: decode = 3'h5;
            `CFG_PAIR2_OFS: decode = 3'h6;
            default:        decode = 3'h0;
         endcase
      end
   endfunction

   // Large first-access codes stretch non-linearly
   function [5:0] first_cycles;
      input [3:0] f;
      begin
         case (f)
            4'hc:    first_cycles = 6'h0d;
            4'hd:    first_cycles = 6'h0f;
            4'he:    first_cycles = 6'h12;
            4'hf:    first_cycles = 6'h17;
            default: first_cycles = {2'h0, f};
         endcase
      end
   endfunction

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // Pins pass three flops; a change counts once stages two and three agree
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= 2'h0;
         in_s2 <= 2'h0;
         in_s3 <= 2'h0;
         rdy_q <= 1'b0;
         strap_q <= 1'b0;
      end else begin
         in_s1 <= {boot_width_16, mem_ready};
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         if (in_s2[0] == in_s3[0]) begin
            rdy_q <= in_s3[0];
         end
         if (in_s2[1] == in_s3[1]) begin
            strap_q <= in_s3[1];
         end
      end
   end

   // Register bus
   wire [2:0] wdec = decode(awaddr_reg);
   wire [2:0] rdec = decode(s_axi_araddr);
   wire       do_write = aw_hold && w_hold && !s_axi_bvalid;
   wire [1:0] widx = wdec[1:0];

   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   integer i;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg[0]   <= `CFG_RESET;
         cfg_reg[1]   <= `CFG_RESET;
         cfg_reg[2]   <= `CFG_RESET;
         awaddr_reg   <= {AW{1'b0}};
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'h0;
         s_axi_rdata  <= 32'h0000_0000;
         strap_cnt    <= 2'h0;
         strap_done   <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
            aw_hold    <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            w_hold    <= 1'b1;
         end
         if (do_write) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wdec[2] ? 2'h0 : 2'h2;
            if (wdec[2]) begin
               for (i = 0; i < 4; i = i + 1) begin
                  if (wstrb_reg[i]) begin
                     cfg_reg[widx][8*i +: 8] <= wdata_reg[8*i +: 8];
                  end
               end
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Width strap is taken once the pin chain has settled after release
         if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `STRAP_WAIT) begin
               strap_done <= 1'b1;
               // Strap flop settles at this same edge, so take its next value
               cfg_reg[0][`WIDTH_BIT] <= (in_s2[1] == in_s3[1]) ? in_s3[1] : strap_q;
            end
         end
         // Read returns the value as written, bit 15 included
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rdec[2] ? 2'h0 : 2'h2;
            s_axi_rdata  <= rdec[2] ? cfg_reg[rdec[1:0]] : 32'h0000_0000;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Access sequencer
   wire        bank_bad  = (req_bank[2:1] == 2'h3);
   wire [31:0] pair_word = bank_bad ? 32'h0000_0000 : cfg_reg[req_bank[2:1]];
   wire [15:0] req_half  = req_bank[0] ? pair_word[31:`ODD_HALF_LSB] : pair_word[15:0];
   wire        req_sync  = !req_bank[2] && sync_static_enable[req_bank[1:0]];
   wire        take      = req_valid && (state_reg == ST_IDLE);

   wire [2:0]  cur_type  = half_reg[`TYPE_MSB:`TYPE_LSB];
   wire [5:0]  cur_first = first_cycles(half_reg[`FIRST_MSB:`FIRST_LSB]);
   wire [5:0]  cur_next  = {2'h0, half_reg[`NEXT_MSB:`NEXT_LSB]};
   wire [5:0]  cur_recov = `RECOV_MULT * {3'h0, half_reg[`RECOV_MSB:`RECOV_LSB]};
   wire        cur_variable_latency_io  = (cur_type == `TYPE_VARIABLE_LATENCY_IO);
   // Reserved type codes run with non-burst ROM timing
   wire        cur_burst = (cur_type == `TYPE_BURST4) || (cur_type == `TYPE_BURST8);
   wire [5:0]  new_first = first_cycles(req_half[`FIRST_MSB:`FIRST_LSB]);
   wire        new_variable_latency_io  = (req_half[`TYPE_MSB:`TYPE_LSB] == `TYPE_VARIABLE_LATENCY_IO);
   wire        beat_end  = tdone && (!cur_variable_latency_io || rdy_q);
   wire        last_beat = (beats_reg == 4'h0);

   // A new transaction is only taken from idle, so no overlap on the bus
   assign req_ready      = (state_reg == ST_IDLE);
   assign sdram_cs_allow = (state_reg != ST_RECOV);

   always @* begin
      state_next = state_reg;
      beats_next = beats_reg;
      tload      = 1'b0;
      tval       = 6'h01;
      case (state_reg)
         ST_IDLE: begin
            if (take && !bank_bad && !(req_sync && !req_write)) begin
               beats_next = req_beats_m1;
               tload      = 1'b1;
               if (req_write) begin
                  state_next = ST_WR;
                  tval       = new_first + `STROBE_ADD;
               end else begin
                  state_next = ST_RD;
                  tval       = new_first + (new_variable_latency_io ? `STROBE_ADD : `FIRST_READ_ADD);
               end
            end
         end
         ST_RD, ST_WR: begin
            if (beat_end) begin
               if (last_beat) begin
                  state_next = (cur_recov == 6'h00) ? ST_IDLE : ST_RECOV;
                  tload      = 1'b1;
                  tval       = cur_recov;
               end else begin
                  beats_next = beats_reg - 4'h1;
                  tload      = 1'b1;
                  if (cur_variable_latency_io) begin
                     state_next = (state_reg == ST_RD) ? ST_RD_GAP : ST_WR_GAP;
                     tval       = cur_next + `STROBE_ADD;
                  end else if (state_reg == ST_WR) begin
                     state_next = ST_WR_GAP;
                     tval       = 6'h01;
                  end else if (cur_burst) begin
                     tval       = cur_next + `STROBE_ADD;
                  end else begin
                     tval       = cur_first + `STROBE_ADD;
                  end
               end
            end
         end
         ST_RD_GAP, ST_WR_GAP: begin
            if (tdone) begin
               state_next = (state_reg == ST_RD_GAP) ? ST_RD : ST_WR;
               tload      = 1'b1;
               tval       = cur_first + `STROBE_ADD;
            end
         end
         ST_RECOV: begin
            if (tdone) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   mem_timer #(.W(6)) u_timer (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .load     (tload),
      .load_val (tval),
      .done     (tdone)
   );

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg         <= ST_IDLE;
         beats_reg         <= 4'h0;
         half_reg          <= 16'h0000;
         req_done          <= 1'b0;
         beat_done         <= 1'b0;
         sync_read_start   <= 1'b0;
         read_stream       <= 1'b0;
         bus_width_16      <= 1'b0;
         chip_select_n     <= 6'h3f;
         output_enable_n   <= 1'b1;
         write_enable_n    <= 1'b1;
         io_write_strobe_n <= 1'b1;
      end else begin
         state_reg       <= state_next;
         beats_reg       <= beats_next;
         req_done        <= 1'b0;
         beat_done       <= 1'b0;
         sync_read_start <= 1'b0;
         if (take) begin
            // Snapshot keeps a running transaction on its own timing
            half_reg     <= req_half;
            bus_width_16 <= req_half[`WIDTH_BIT];
            read_stream  <= req_half[`RBUFF_BIT] | req_sync;
            if (bank_bad || (req_sync && !req_write)) begin
               // Sync reads belong to the sync engine; only the width bit of this half is used
               req_done        <= 1'b1;
               sync_read_start <= !bank_bad;
            end else begin
               chip_select_n[req_bank] <= 1'b0;
               if (!req_write) begin
                  output_enable_n <= 1'b0;
               end else if (req_half[`TYPE_MSB:`TYPE_LSB] == `TYPE_VARIABLE_LATENCY_IO) begin
                  io_write_strobe_n <= 1'b0;
               end else begin
                  write_enable_n <= 1'b0;
               end
            end
         end
         case (state_reg)
            ST_RD, ST_WR: begin
               if (beat_end) begin
                  beat_done         <= 1'b1;
                  write_enable_n    <= 1'b1;
                  io_write_strobe_n <= 1'b1;
                  if (last_beat || cur_variable_latency_io) begin
                     output_enable_n <= 1'b1;
                  end
                  if (last_beat) begin
                     chip_select_n <= 6'h3f;
                     req_done      <= 1'b1;
                  end
               end
            end
            ST_RD_GAP: begin
               if (tdone) begin
                  output_enable_n <= 1'b0;
               end
            end
            ST_WR_GAP: begin
               if (tdone) begin
                  write_enable_n    <= cur_variable_latency_io;
                  io_write_strobe_n <= !cur_variable_latency_io;
               end
            end
            default: begin
            end
         endcase
      end
   end

endmodule

// ==== pkg/static_mem_map.vh ====
`ifndef STATIC_MEM_MAP_VH
`define STATIC_MEM_MAP_VH

// Register byte offsets
`define CFG_PAIR0_OFS   8'h08
`define CFG_PAIR1_OFS   8'h0c
`define CFG_PAIR2_OFS   8'h10

// Field positions inside one 16-bit bank half
`define TYPE_MSB        2
`define TYPE_LSB        0
`define WIDTH_BIT       3
`define FIRST_MSB       7
`define FIRST_LSB       4
`define NEXT_MSB        11
`define NEXT_LSB        8
`define RECOV_MSB       14
`define RECOV_LSB       12
`define RBUFF_BIT       15
`define ODD_HALF_LSB    16

// Reset value of every register (bit 3 of pair 0 comes from the strap)
`define CFG_RESET       32'h7ff0_7ff0

// Memory type codes
`define TYPE_ROM        3'h0
`define TYPE_SRAM       3'h1
`define TYPE_BURST4     3'h2
`define TYPE_BURST8     3'h3
`define TYPE_VARIABLE_LATENCY_IO       3'h4

// Timing adders and multiplier, in memory clocks
`define FIRST_READ_ADD  6'h02
`define STROBE_ADD      6'h01
`define RECOV_MULT      6'h02

// Cycles after reset release before the width strap is taken
`define STRAP_WAIT      2'h3

`endif

// ==== sim/static_memory_timing_config_properties.sv ====
`timescale 1ns/10ps
module static_memory_timing_config_properties (
   input wire        mclk,
   input wire        rst_b,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        req_valid,
   input wire        req_ready,
   input wire [2:0]  req_bank,
   input wire        req_write,
   input wire        req_done,
   input wire [3:0]  sync_static_enable,
   input wire [5:0]  chip_select_n,
   input wire        output_enable_n,
   input wire        write_enable_n,
   input wire        io_write_strobe_n,
   input wire        sdram_cs_allow
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   one_bank_a: assert property ($onehot0(~chip_select_n))
      else $error("two chip selects low");
   one_strobe_a: assert property (
      $onehot0({~output_enable_n, ~write_enable_n, ~io_write_strobe_n}))
      else $error("two strobes low");
   strobe_cs_a: assert property (
      !(output_enable_n && write_enable_n && io_write_strobe_n) |-> chip_select_n != 6'h3f)
      else $error("strobe without chip select");
   idle_ready_a: assert property (req_ready |-> &chip_select_n)
      else $error("ready during transaction");
   done_release_a: assert property (req_done |-> &chip_select_n)
      else $error("chip select low at done");
   recovery_gap_a: assert property (
      !sdram_cs_allow |-> &chip_select_n && !req_ready)
      else $error("select during recovery");
   take_select_a: assert property (
      req_valid && req_ready && req_bank < 3'h6 &&
      (req_write || req_bank > 3'h3 || !sync_static_enable[req_bank[1:0]])
      |=> chip_select_n == ~(6'h01 << $past(req_bank)))
      else $error("wrong chip select after take");
   write_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   read_hold_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 (s_axi_rready or
      (##1 s_axi_rvalid && $stable(s_axi_rdata))))
      else $error("read answer not held");
   cover property (req_done ##1 !sdram_cs_allow);
   cover property (!io_write_strobe_n);
   cover property (!write_enable_n ##1 write_enable_n);
endmodule

// ==== sim/static_memory_timing_config_test.sv ====
`timescale 1ns/10ps
`include "static_mem_map.vh"
module static_memory_timing_config_test;
   reg         mclk, rst_b, awvalid, wvalid, bready, arvalid, rready, req_valid, req_write;
   reg         slow, strm, wid, sync_seen;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, rd;
   reg  [3:0]  sync_en, req_beats_m1;
   reg  [2:0]  req_bank;
   reg  [1:0]  rs;
   reg  [15:0] h, k;
   wire        awready, wready, bvalid, arready, rvalid, req_ready, req_done, beat_done;
   wire        sync_read_start, read_stream, bus_width_16, mem_ready, sdram_cs_allow;
   wire        output_enable_n, write_enable_n, io_write_strobe_n;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [5:0]  chip_select_n;
   integer     failures, check_count, n_strobe, n_gap, n_beat, first_b, last_b, rec;
   integer     i, f, g, n, r, t, m;
   static_memory_timing_config u_static_memory_timing_config (
      .mclk(mclk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sync_static_enable(sync_en), .boot_width_16(1'b1), .req_valid(req_valid),
      .req_ready(req_ready), .req_bank(req_bank), .req_write(req_write),
      .req_beats_m1(req_beats_m1), .req_done(req_done), .beat_done(beat_done),
      .sync_read_start(sync_read_start), .read_stream(read_stream),
      .bus_width_16(bus_width_16), .mem_ready(mem_ready), .chip_select_n(chip_select_n),
      .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
      .io_write_strobe_n(io_write_strobe_n), .sdram_cs_allow(sdram_cs_allow));
   variable_latency_io_ready_model u_variable_latency_io_ready_model (.mclk(mclk), .slow(slow), .chip_select_n(chip_select_n),
      .output_enable_n(output_enable_n), .io_write_strobe_n(io_write_strobe_n),
      .mem_ready(mem_ready));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   function [15:0] hw(input integer rb, rr, nn, ff, ww, tt);
      hw = {rb[0], rr[2:0], nn[3:0], ff[3:0], ww[0], tt[2:0]};
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task axi_wr(input [7:0] a, input [31:0] d);
      reg done;
      begin
         @(posedge mclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
               rs = bresp;
               bready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
   task axi_rd(input [7:0] a);
      reg done;
      begin
         @(posedge mclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         done = 1'b0;
         while (!done) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
               rd = rdata;
               rs = rresp;
               rready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
   // Readback before any access, so a type change has landed first
   task cfg(input integer p, input [31:0] d);
      begin
         axi_wr(`CFG_PAIR0_OFS + {p[5:0], 2'h0}, d);
         axi_rd(`CFG_PAIR0_OFS + {p[5:0], 2'h0});
         chk(rd, d);
      end
   endtask
   // Counts are sampled values of whole memory clocks after the take edge
   task acc(input [2:0] b, input w, input [3:0] bm);
      integer c;
      begin
         {n_strobe, n_gap, n_beat, first_b, last_b, rec, c} = 0;
         sync_seen = 1'b0;
         @(posedge mclk);
         req_bank <= b;
         req_write <= w;
         req_beats_m1 <= bm;
         req_valid <= 1'b1;
         @(posedge mclk);
         while (!req_ready) @(posedge mclk);
         req_valid <= 1'b0;
         while (!req_done) begin
            @(posedge mclk);
            c = c + 1;
            if (!(output_enable_n & write_enable_n & io_write_strobe_n)) n_strobe = n_strobe + 1;
            else if (chip_select_n != 6'h3f) n_gap = n_gap + 1;
            if (beat_done) begin
               if (n_beat == 0) first_b = c;
               last_b = c;
               n_beat = n_beat + 1;
            end
            if (!sdram_cs_allow) rec = rec + 1;
            if (sync_read_start) sync_seen = 1'b1;
            strm = read_stream;
            wid = bus_width_16;
         end
         while (!req_ready) begin
            @(posedge mclk);
            if (!sdram_cs_allow) rec = rec + 1;
         end
      end
   endtask
   initial begin
      {rst_b, awvalid, wvalid, bready, arvalid, rready, req_valid, req_write, slow} = 0;
      {awaddr, araddr, wdata, sync_en, req_beats_m1, req_bank} = 0;
      {failures, check_count} = 0;
      i = $urandom(69719);
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (10) @(posedge mclk);
      for (i = 0; i < 3; i = i + 1) begin
         axi_rd(`CFG_PAIR0_OFS + {i[5:0], 2'h0});
         chk(rd, `CFG_RESET | ((i == 0) ? 32'h8 : 32'h0));
      end
      axi_rd(8'h00);
      chk({rs, rd[29:0]}, 32'h8000_0000);
      axi_wr(8'h14, 32'h0);
      chk(rs, 2'h2);
      $display("test reset done");
      for (t = 0; t < 8; t = t + 1) if (t != 4) begin
         f = $urandom % 12;
         r = $urandom % 8;
         g = $urandom % 2;
         m = $urandom % 2;
         h = hw(g, r, 0, f, m, t);
         cfg(2, {h, h});
         acc(5, 1'b0, 4'h0);
         chk(n_strobe, f + 2);
         chk(first_b, f + 3);
         chk(rec, 2 * r);
         chk(strm, g);
         chk(wid, m);
      end
      $display("test types done");
      for (i = 0; i < 3; i = i + 1) begin
         t = (i == 0) ? 0 : i + 1;
         m = (t == 3) ? 7 : 3;
         f = $urandom % 12;
         n = $urandom % 16;
         h = hw(1, 0, n, f, 0, t);
         cfg(2, {h, h});
         acc(5, 1'b0, m);
         chk(n_beat, m + 1);
         chk(last_b - first_b, m * ((t == 0) ? f + 1 : n + 1));
      end
      $display("test bursts done");
      f = $urandom % 12;
      g = $urandom % 12;
      cfg(1, {hw(0, 0, 0, g, 0, 1), hw(0, 0, 0, f, 0, 1)});
      acc(2, 1'b1, 4'h1);
      chk(n_strobe, 2 * (f + 1));
      chk(n_gap, 1);
      acc(3, 1'b1, 4'h0);
      chk(n_strobe, g + 1);
      $display("test halves done");
      slow <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         n = 2 + $urandom % 14;
         h = hw(0, 1, n, $urandom % 12, 0, 4);
         cfg(0, {h, h});
         acc(1, i[0], 4'h1);
         chk(n_beat, 2);
         chk(n_gap, n + 1);
      end
      $display("test variable_latency_io done");
      i = $urandom;
      sync_en <= {i[2:0], 1'b1};
      f = $urandom % 12;
      m = $urandom % 2;
      h = hw(0, 1, 3, f, m, 1);
      cfg(0, {h, h});
      chk(rd[15], 1'b0);
      acc(0, 1'b0, 4'h0);
      chk({sync_seen, n_strobe[3:0]}, 5'h10);
      chk(strm, 1'b1);
      chk(wid, m);
      acc(0, 1'b1, 4'h0);
      chk(n_strobe, f + 1);
      // Bank without a register finishes at once with no strobes
      acc(6, 1'b0, 4'h0);
      chk({sync_seen, n_strobe[3:0], n_beat[3:0]}, 9'h000);
      $display("test sync done");
      f = 6 + $urandom % 6;
      g = $urandom % 6;
      h = hw(0, 0, 0, f, 0, 0);
      k = hw(0, 0, 0, g, 0, 0);
      cfg(2, {h, h});
      fork
         acc(5, 1'b0, 4'h0);
         begin
            repeat (3) @(posedge mclk);
            axi_wr(`CFG_PAIR2_OFS, {k, k});
         end
      join
      chk(n_strobe, f + 2);
      acc(5, 1'b0, 4'h0);
      chk(n_strobe, g + 2);
      $display("test snapshot done");
      finish_test;
   end
   // Whole run is under a thousand clocks; the limit of 20000 leaves wide margin
   initial begin
      #400000;
      failures = failures + 1;
      finish_test;
   end
endmodule
bind static_memory_timing_config static_memory_timing_config_properties u_props (
   .mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .req_valid(req_valid),
   .req_ready(req_ready), .req_bank(req_bank), .req_write(req_write), .req_done(req_done),
   .sync_static_enable(sync_static_enable), .chip_select_n(chip_select_n),
   .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
   .io_write_strobe_n(io_write_strobe_n), .sdram_cs_allow(sdram_cs_allow));

// ==== sim/variable_latency_io_ready_model.sv ====
`timescale 1ns/10ps
module variable_latency_io_ready_model (
   input  wire       mclk,
   input  wire       slow,
   input  wire [5:0] chip_select_n,
   input  wire       output_enable_n,
   input  wire       io_write_strobe_n,
   output reg        mem_ready
);
   reg [1:0] hold_reg;
   reg       idle_reg;
   initial begin
      mem_ready = 1'b1;
      hold_reg = 2'h0;
      idle_reg = 1'b1;
   end
   // Slow device stalls three clocks at every strobe start; line pulled up otherwise
   always @(posedge mclk) begin
      idle_reg <= output_enable_n & io_write_strobe_n;
      if (slow && idle_reg && !(output_enable_n & io_write_strobe_n) && chip_select_n != 6'h3f)
         hold_reg <= 2'h3;
      else if (hold_reg != 2'h0)
         hold_reg <= hold_reg - 2'h1;
      mem_ready <= (hold_reg == 2'h0);
   end
endmodule
